// file: include/iec_pkg.sv
// constants for the two-wire event control block
package iec_pkg;
  // register index on the cpu port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_SR1 = 2'h1;
  localparam logic [1:0] ADDR_SR2 = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;
  // bus_control fields
  localparam int CTRL_ENABLE = 5;
  localparam int CTRL_GC_EN = 4;
  localparam int CTRL_START = 3;
  localparam int CTRL_ACK = 2;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_IRQ_EN = 0;
  // first status register fields
  localparam int SR1_EVENT = 7;
  localparam int SR1_HEADER = 6;
  localparam int SR1_TRA = 5;
  localparam int SR1_BUSY = 4;
  localparam int SR1_BYTE = 3;
  localparam int SR1_ADDR = 2;
  localparam int SR1_MASTER = 1;
  localparam int SR1_START = 0;
  // second status register fields
  localparam int SR2_ACKFAIL = 4;
  localparam int SR2_STOP = 3;
  localparam int SR2_ARB = 2;
  localparam int SR2_BUS_ERROR_FLAG = 1;
  localparam int SR2_GCALL = 0;
  // reset values and special bytes
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [7:0] NACK_RELEASE_BYTE = 8'hff;
endpackage

// file: hw/iec_line_mon.sv
// line monitor: synchronises clock and data lines, finds start and stop
`timescale 1ns/1ps
module iec_line_mon (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // conditions seen on the bus
  output logic start_det,
  output logic stop_det
);
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic start_det;
    logic stop_det;
  } iec_mon_t;

  iec_mon_t st;
  iec_mon_t next_st;

  always_comb begin
    next_st = st;
    // first stage feeds only the second stage
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};
    next_st.scl_prev = st.scl_sync[1];
    next_st.sda_prev = st.sda_sync[1];
    // data moves while clock stays high
    next_st.start_det = st.scl_prev && st.scl_sync[1] && st.sda_prev && !st.sda_sync[1];
    next_st.stop_det = st.scl_prev && st.scl_sync[1] && !st.sda_prev && st.sda_sync[1];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
              start_det: 1'b0, stop_det: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign start_det = st.start_det;
  assign stop_det = st.stop_det;
endmodule // iec_line_mon

// file: hw/iec_event_ctrl.sv
// event flags, two-step clears, bus_control and clock stretch of the two-wire port
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - address match sets flags; first status read clears
// - received byte sets flags; status then data read
// - sent byte sets flags; status read then data write
// - slave nack sets failure and byte flags
// - nack byte flag cleared by stop pulse or ffh
// - stop pulse release hides following stop event
// - slave stop sets flags; second status read clears
// - start sent sets flags; status read, data write
// - address done event; status read, control write
// - header sent sets flags; status read, data write
// - clock held low while any blocking flag set, unless slave stop releases lines
// - light sleep runs normally, interrupts wake cpu
// - deep stop freezes, no ack, no wake
// - one interrupt, gated by enable and cpu mask
// - bits 7:6 zero; disable resets all but stop
// - first enabling write sets only enable bit
// - general call acks 00h only; cleared on disable
// - general call addressed slave only receives
// - start bit: repeated start or start when free
// - ack bit acknowledges received address and data
// - master stop after byte, hardware clears it
// - slave stop releases lines, software clears it
// - start with bus idle enters master mode
// - error flags clear on second status read
module iec_event_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // cpu register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu power and interrupt
  input wire logic cpu_int_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic irq_req,
  output logic wake_req,
  // transfer engine reports
  input wire logic eng_addr_valid,
  input wire logic [7:0] eng_addr_byte,
  input wire logic eng_own_match,
  input wire logic eng_byte_done,
  input wire logic eng_byte_tx,
  input wire logic [7:0] eng_rx_byte,
  input wire logic eng_nack,
  input wire logic eng_start_sent,
  input wire logic eng_header_sent,
  input wire logic eng_addr_done,
  input wire logic eng_stop_sent,
  input wire logic eng_arb_lost,
  input wire logic eng_bus_error,
  // transfer engine controls
  output logic ack_enable,
  output logic start_req,
  output logic stop_req,
  output logic release_req,
  output logic slave_tx_allow,
  output logic master_mode_flag,
  output logic [7:0] tx_byte,
  output logic tx_byte_load,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n
);
  typedef struct packed {
    // bus_control
    logic interface_enable;
    logic general_call_enable;
    logic start;
    logic ack;
    logic stop;
    logic interrupt_enable_bit;
    // first status register
    logic event_flag;
    logic header_sent_flag;
    logic tra;
    logic busy;
    logic byte_finished_flag;
    logic address_matched_flag;
    logic master_mode_flag;
    logic start_sent_flag;
    // second status register
    logic ack_failure_flag;
    logic stop_detected_flag;
    logic arbitration_lost_flag;
    logic bus_error_flag;
    logic general_call_seen;
    // sequencing state
    logic address_complete_event;
    logic sr1_seen;
    logic nack_pending;
    logic stop_hidden;
    logic addressed;
    logic [7:0] data;
    logic [7:0] rdata;
    // registered outputs
    logic irq;
    logic wake;
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic release_req;
    logic slave_tx_allow;
    logic [7:0] tx_byte;
    logic tx_load;
    logic scl_oe_n;
  } iec_state_t;

  iec_state_t st;
  iec_state_t next_st;
  logic start_det;
  logic stop_det;

  iec_line_mon u_line_mon (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  always_comb begin
    logic rd_sr1;
    logic rd_sr2;
    logic rd_data;
    logic wr_data;
    logic wr_ctrl;
    logic gc_hit;
    logic hold;
    rd_sr1 = reg_rd && (reg_addr == iec_pkg::ADDR_SR1);
    rd_sr2 = reg_rd && (reg_addr == iec_pkg::ADDR_SR2);
    rd_data = reg_rd && (reg_addr == iec_pkg::ADDR_DATA);
    wr_data = reg_wr && (reg_addr == iec_pkg::ADDR_DATA);
    wr_ctrl = reg_wr && (reg_addr == iec_pkg::ADDR_CTRL);
    gc_hit = st.general_call_enable && (eng_addr_byte == iec_pkg::GCALL_ADDR);
    hold = 1'b0;
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.tx_load = 1'b0;
    // deep stop leaves every register but the read data, load strobe, ack enable and wake as it stands
    if (!halt_mode) begin
      if (reg_rd) begin
        case (reg_addr)
          iec_pkg::ADDR_CTRL: begin
            // top two bits always read zero
            next_st.rdata = {2'b00, st.interface_enable, st.general_call_enable, st.start,
                             st.ack, st.stop, st.interrupt_enable_bit};
          end
          iec_pkg::ADDR_SR1: begin
            next_st.rdata = {st.event_flag, st.header_sent_flag, st.tra, st.busy,
                             st.byte_finished_flag, st.address_matched_flag,
                             st.master_mode_flag, st.start_sent_flag};
          end
          iec_pkg::ADDR_SR2: begin
            next_st.rdata = {3'b000, st.ack_failure_flag, st.stop_detected_flag,
                             st.arbitration_lost_flag, st.bus_error_flag,
                             st.general_call_seen};
          end
          iec_pkg::ADDR_DATA: begin
            next_st.rdata = st.data;
          end
          default: begin
            next_st.rdata = 8'h00;
          end
        endcase
      end

      // software clears come first so that a same-cycle set wins
      if (rd_sr1) begin
        next_st.sr1_seen = 1'b1;
        next_st.address_matched_flag = 1'b0;
        next_st.ack_failure_flag = 1'b0;
      end
      if (rd_sr2) begin
        next_st.ack_failure_flag = 1'b0;
        next_st.stop_detected_flag = 1'b0;
        next_st.arbitration_lost_flag = 1'b0;
        next_st.bus_error_flag = 1'b0;
      end
      if (rd_data && st.sr1_seen) begin
        next_st.sr1_seen = 1'b0;
        if (!st.tra) begin
          next_st.byte_finished_flag = 1'b0;
        end
      end
      if (wr_data) begin
        next_st.data = reg_wdata;
        next_st.tx_byte = reg_wdata;
        next_st.tx_load = 1'b1;
        if (st.sr1_seen) begin
          next_st.sr1_seen = 1'b0;
          next_st.start_sent_flag = 1'b0;
          next_st.header_sent_flag = 1'b0;
          if (st.tra) begin
            next_st.byte_finished_flag = 1'b0;
            next_st.tra = 1'b0;
          end
        end
        // an all-ones byte lets a refused slave transmitter drop out
        if (st.nack_pending && (reg_wdata == iec_pkg::NACK_RELEASE_BYTE)) begin
          next_st.byte_finished_flag = 1'b0;
          next_st.nack_pending = 1'b0;
          next_st.tra = 1'b0;
        end
      end
      if (wr_ctrl) begin
        if (!st.interface_enable) begin
          // waking write only turns the port on
          next_st.interface_enable = reg_wdata[iec_pkg::CTRL_ENABLE];
        end else begin
          next_st.interface_enable = reg_wdata[iec_pkg::CTRL_ENABLE];
          next_st.general_call_enable = reg_wdata[iec_pkg::CTRL_GC_EN];
          next_st.start = reg_wdata[iec_pkg::CTRL_START];
          next_st.ack = reg_wdata[iec_pkg::CTRL_ACK];
          next_st.stop = reg_wdata[iec_pkg::CTRL_STOP];
          next_st.interrupt_enable_bit = reg_wdata[iec_pkg::CTRL_IRQ_EN];
          if (st.sr1_seen) begin
            next_st.sr1_seen = 1'b0;
            next_st.address_complete_event = 1'b0;
          end
        end
        // stop raised then dropped while refused: lines let go
        if (st.nack_pending && st.stop && !reg_wdata[iec_pkg::CTRL_STOP]) begin
          next_st.byte_finished_flag = 1'b0;
          next_st.nack_pending = 1'b0;
          next_st.tra = 1'b0;
          next_st.stop_hidden = 1'b1;
        end
      end

      // bus conditions; ignored while disabled, when busy is held clear
      if (st.interface_enable && start_det) begin
        next_st.busy = 1'b1;
      end
      if (st.interface_enable && stop_det) begin
        next_st.busy = 1'b0;
        next_st.master_mode_flag = 1'b0;
        next_st.general_call_seen = 1'b0;
        next_st.tra = 1'b0;
        next_st.addressed = 1'b0;
        next_st.stop_hidden = 1'b0;
        if (!st.master_mode_flag && st.addressed && !st.stop_hidden) begin
          next_st.stop_detected_flag = 1'b1;
        end
      end

      // hardware sets from the transfer engine
      if (st.interface_enable) begin
        if (eng_addr_valid && st.ack && (eng_own_match || gc_hit)) begin
          next_st.address_matched_flag = 1'b1;
          next_st.addressed = 1'b1;
          next_st.general_call_seen = gc_hit;
        end
        if (eng_byte_done) begin
          next_st.byte_finished_flag = 1'b1;
          next_st.tra = eng_byte_tx;
          if (!eng_byte_tx) begin
            next_st.data = eng_rx_byte;
          end
        end
        if (eng_nack) begin
          next_st.ack_failure_flag = 1'b1;
          if (!st.master_mode_flag) begin
            next_st.byte_finished_flag = 1'b1;
            next_st.tra = 1'b1;
            next_st.nack_pending = 1'b1;
          end
        end
        if (eng_start_sent) begin
          next_st.start_sent_flag = 1'b1;
          next_st.start = 1'b0;
          next_st.master_mode_flag = 1'b1;
        end
        if (eng_header_sent) begin
          next_st.header_sent_flag = 1'b1;
        end
        if (eng_addr_done) begin
          next_st.address_complete_event = 1'b1;
        end
        if (eng_stop_sent && st.master_mode_flag) begin
          next_st.stop = 1'b0;
          next_st.master_mode_flag = 1'b0;
        end
        if (eng_arb_lost) begin
          next_st.arbitration_lost_flag = 1'b1;
          next_st.master_mode_flag = 1'b0;
          next_st.tra = 1'b0;
        end
        if (eng_bus_error) begin
          next_st.bus_error_flag = 1'b1;
          next_st.busy = 1'b0;
        end
        // idle bus and a start request: take the master role
        if (st.start && !st.busy && !st.master_mode_flag) begin
          next_st.master_mode_flag = 1'b1;
        end
      end

      // disabling clears all but the stop bit
      if (!next_st.interface_enable) begin
        next_st.general_call_enable = 1'b0;
        next_st.start = 1'b0;
        next_st.ack = 1'b0;
        next_st.interrupt_enable_bit = 1'b0;
        next_st.header_sent_flag = 1'b0;
        next_st.tra = 1'b0;
        next_st.busy = 1'b0;
        next_st.byte_finished_flag = 1'b0;
        next_st.address_matched_flag = 1'b0;
        next_st.master_mode_flag = 1'b0;
        next_st.start_sent_flag = 1'b0;
        next_st.ack_failure_flag = 1'b0;
        next_st.stop_detected_flag = 1'b0;
        next_st.arbitration_lost_flag = 1'b0;
        next_st.bus_error_flag = 1'b0;
        next_st.general_call_seen = 1'b0;
        next_st.address_complete_event = 1'b0;
        next_st.sr1_seen = 1'b0;
        next_st.nack_pending = 1'b0;
        next_st.stop_hidden = 1'b0;
        next_st.addressed = 1'b0;
      end

      next_st.event_flag = next_st.byte_finished_flag | next_st.address_matched_flag
                           | next_st.start_sent_flag | next_st.ack_failure_flag
                           | next_st.stop_detected_flag | next_st.arbitration_lost_flag
                           | next_st.bus_error_flag | next_st.header_sent_flag
                           | next_st.address_complete_event;
      // one shared line, gated by enable bit and cpu mask
      next_st.irq = next_st.event_flag && next_st.interrupt_enable_bit
                    && !cpu_int_mask;
      next_st.start_req = next_st.start;
      next_st.stop_req = next_st.stop && next_st.master_mode_flag;
      // slave stop stays set until software drops it
      next_st.release_req = next_st.interface_enable && next_st.stop
                            && !next_st.master_mode_flag;
      next_st.slave_tx_allow = next_st.interface_enable
                               && !next_st.general_call_seen;
      hold = next_st.header_sent_flag | next_st.start_sent_flag
             | next_st.byte_finished_flag | next_st.address_matched_flag
             | next_st.address_complete_event;
      // released lines win over a stretch so the bus can recover
      next_st.scl_oe_n = !(next_st.interface_enable && hold && !next_st.release_req);
    end
    // power mode terms act even while frozen
    next_st.ack_en = next_st.interface_enable && next_st.ack && !halt_mode;
    next_st.wake = next_st.irq && wait_mode && !halt_mode;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.scl_oe_n <= 1'b1;
      st.data <= iec_pkg::DATA_RESET;
      st.tx_byte <= iec_pkg::DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq_req = st.irq;
  assign wake_req = st.wake;
  assign ack_enable = st.ack_en;
  assign start_req = st.start_req;
  assign stop_req = st.stop_req;
  assign release_req = st.release_req;
  assign slave_tx_allow = st.slave_tx_allow;
  assign master_mode_flag = st.master_mode_flag;
  assign tx_byte = st.tx_byte;
  assign tx_byte_load = st.tx_load;
  // the line is only ever pulled low, never driven high
  assign scl_out = 1'b0;
  assign scl_oe_n = st.scl_oe_n;
endmodule // iec_event_ctrl

// file: tb/iec_event_chk.sv
// assertions on the cpu port, power gating and clock stretch
`timescale 1ns/1ps
module iec_event_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // cpu port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // power and interrupt
  input wire logic cpu_int_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic irq_req,
  input wire logic wake_req,
  // engine controls and pin
  input wire logic ack_enable,
  input wire logic stop_req,
  input wire logic release_req,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_load,
  input wire logic scl_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic sr1_rd;
  logic ctrl_rd;
  assign sr1_rd = reg_rd && reg_addr == iec_pkg::ADDR_SR1 && !halt_mode;
  assign ctrl_rd = reg_rd && reg_addr == iec_pkg::ADDR_CTRL;
  a_ctrl_top_zero: assert property ($past(ctrl_rd) |-> reg_rdata[7:6] == 2'h0)
    else $error("control read shows reserved bits set");
  a_irq_gated: assert property (irq_req && !$past(halt_mode) |-> !$past(cpu_int_mask))
    else $error("interrupt raised while cpu mask set");
  a_wake_in_wait: assert property (wake_req |-> irq_req && $past(wait_mode))
    else $error("wake without interrupt in light sleep");
  a_halt_no_wake: assert property ($past(halt_mode) |-> !wake_req)
    else $error("wake request during deep stop");
  a_halt_no_ack: assert property ($past(halt_mode) |-> !ack_enable)
    else $error("acknowledge enabled during deep stop");
  a_halt_freeze: assert property ($past(halt_mode) |-> $stable(tx_byte) && !tx_byte_load)
    else $error("registers moved during deep stop");
  a_load_from_write: assert property (tx_byte_load |->
    $past(reg_wr && reg_addr == iec_pkg::ADDR_DATA) && tx_byte == $past(reg_wdata))
    else $error("transmit byte load without data write");
  a_stretch_held: assert property ($past(sr1_rd) && (reg_rdata & 8'h49) != 8'h00 |-> !scl_oe_n)
    else $error("clock not stretched while blocking flag set");
  a_stop_split: assert property (!(stop_req && release_req))
    else $error("master stop and slave release together");
  c_sr1_event: cover property ($past(sr1_rd) && reg_rdata[iec_pkg::SR1_EVENT]);
  c_irq: cover property (irq_req);
  c_wake: cover property (wake_req);
  c_release: cover property (release_req);
endmodule // iec_event_chk

bind iec_event_ctrl iec_event_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_int_mask(cpu_int_mask), .wait_mode(wait_mode),
  .halt_mode(halt_mode), .irq_req(irq_req), .wake_req(wake_req), .ack_enable(ack_enable),
  .stop_req(stop_req), .release_req(release_req), .tx_byte(tx_byte),
  .tx_byte_load(tx_byte_load), .scl_oe_n(scl_oe_n));

// file: tb/iec_bus_peer.sv
// bus peer: another master making start and stop on the shared lines
`timescale 1ns/1ps
module iec_bus_peer (
  // peer line levels, pulled high when released
  output logic scl,
  output logic sda
);
  localparam time HALF = 80ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // data falls under high clock, clock then parks low inside the frame
  task automatic start_cond();
    sda = 1'b0;
    #HALF scl = 1'b0;
    #HALF;
  endtask
  // data low under low clock, clock rises, data rises; clock stays still after
  task automatic stop_cond();
    sda = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask
endmodule // iec_bus_peer

// file: tb/test_i2c_event_control.sv
// self-checking bench of the two-wire event control block
`timescale 1ns/1ps
module test_i2c_event_control;
  localparam logic [1:0] CT = iec_pkg::ADDR_CTRL;
  localparam logic [1:0] S1 = iec_pkg::ADDR_SR1;
  localparam logic [1:0] S2 = iec_pkg::ADDR_SR2;
  localparam logic [1:0] DT = iec_pkg::ADDR_DATA;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_int_mask = 1'b0;
  logic wait_mode = 1'b0;
  logic halt_mode = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [7:0] ab = 8'h00;
  logic om = 1'b0;
  logic eng_tx = 1'b0;
  logic [7:0] rx = 8'h00;
  logic [7:0] reg_rdata, tx_byte, d;
  logic irq_req, wake_req, ack_enable, start_req, stop_req, release_req;
  logic slave_tx_allow, master_mode_flag, tx_byte_load, scl_out, scl_oe_n;
  logic peer_scl, peer_sda, scl_wire;
  int err_count = 0;
  int checks_done = 0;
  always #10 sys_clk = ~sys_clk;
  // open-drain clock: peer or the stretch pulls it low
  assign scl_wire = peer_scl & scl_oe_n;
  iec_bus_peer peer (.scl(peer_scl), .sda(peer_sda));
  iec_event_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_int_mask(cpu_int_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
    .irq_req(irq_req), .wake_req(wake_req), .eng_addr_valid(ev[0]), .eng_addr_byte(ab),
    .eng_own_match(om), .eng_byte_done(ev[1]), .eng_byte_tx(eng_tx), .eng_rx_byte(rx),
    .eng_nack(ev[2]), .eng_start_sent(ev[3]), .eng_header_sent(ev[4]),
    .eng_addr_done(ev[5]), .eng_stop_sent(ev[6]), .eng_arb_lost(ev[7]),
    .eng_bus_error(ev[8]), .ack_enable(ack_enable), .start_req(start_req),
    .stop_req(stop_req), .release_req(release_req), .slave_tx_allow(slave_tx_allow),
    .master_mode_flag(master_mode_flag), .tx_byte(tx_byte), .tx_byte_load(tx_byte_load),
    .scl_in(scl_wire), .sda_in(peer_sda), .scl_out(scl_out), .scl_oe_n(scl_oe_n));
  function automatic logic [7:0] sr1_of(input logic busy, input logic tra,
      input logic byte_f, input logic addr_f);
    return {1'b1, 1'b0, tra, busy, byte_f, addr_f, 2'b00};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // let the write land before the caller looks at outputs
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk8(d, exp);
  endtask
  task automatic fire(input logic [8:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 9'h000;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("counts: checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400us;
    err_count++;
    final_report();
  end
  initial begin
    logic [7:0] v;
    void'($urandom(61816));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rchk(CT, iec_pkg::CTRL_RESET);
    rchk(S2, 8'h00);
    chk1(scl_oe_n, 1'b1);
    // first enabling write only sets enable; stop survives disable
    wr(CT, 8'hf7);
    rchk(CT, 8'h20);
    wr(CT, 8'hf7);
    rchk(CT, 8'h37);
    chk1(release_req, 1'b1);
    wr(CT, 8'h02);
    rchk(CT, 8'h02);
    chk1(ack_enable, 1'b0);
    wr(CT, 8'h20);
    wr(CT, 8'h35);
    rchk(CT, 8'h35);
    chk1(ack_enable, 1'b1);
    $display("test control done");
    // frame one: own address, bytes both ways, nack with stop pulse release
    peer.start_cond();
    ab <= 8'($urandom) | 8'h02;
    om <= 1'b1;
    fire(9'h001);
    chk1(scl_oe_n, 1'b0);
    chk1(irq_req, 1'b1);
    cpu_int_mask <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk1(irq_req, 1'b0);
    cpu_int_mask <= 1'b0;
    rchk(S1, sr1_of(1'b1, 1'b0, 1'b0, 1'b1));
    rchk(S1, 8'h10);
    chk1(scl_oe_n, 1'b1);
    for (int i = 0; i < 8; i++) begin
      eng_tx <= i[0];
      rx <= 8'($urandom);
      fire(9'h002);
      chk1(scl_oe_n, 1'b0);
      rchk(S1, sr1_of(1'b1, i[0], 1'b1, 1'b0));
      if (i[0]) begin
        v = 8'($urandom);
        wr(DT, v);
        chk8(tx_byte, v);
      end else begin
        rchk(DT, rx);
      end
      rchk(S1, 8'h10);
    end
    eng_tx <= 1'b1;
    fire(9'h004);
    rchk(S1, sr1_of(1'b1, 1'b1, 1'b1, 1'b0));
    rchk(S2, 8'h00);
    wr(DT, iec_pkg::NACK_RELEASE_BYTE);
    rchk(S1, 8'h10);
    fire(9'h004);
    rchk(S1, sr1_of(1'b1, 1'b1, 1'b1, 1'b0));
    wr(CT, 8'h37);
    wr(CT, 8'h35);
    rchk(S1, 8'h10);
    peer.stop_cond();
    repeat (8) @(posedge sys_clk);
    rchk(S2, 8'h00);
    $display("test slave frame done");
    // frame two: 01h ignored, general call taken, stop reported
    peer.start_cond();
    ab <= 8'h01;
    om <= 1'b0;
    fire(9'h001);
    rchk(S1, 8'h10);
    ab <= iec_pkg::GCALL_ADDR;
    fire(9'h001);
    rchk(S1, sr1_of(1'b1, 1'b0, 1'b0, 1'b1));
    rchk(S2, 8'h01);
    chk1(slave_tx_allow, 1'b0);
    peer.stop_cond();
    repeat (8) @(posedge sys_clk);
    rchk(S2, 8'h08);
    rchk(S2, 8'h00);
    chk1(slave_tx_allow, 1'b1);
    fire(9'h180);
    rchk(S2, 8'h06);
    rchk(S2, 8'h00);
    $display("test general call done");
    // master events and their two-step clears
    wr(CT, 8'h3d);
    chk1(start_req, 1'b1);
    @(posedge sys_clk);
    #1 chk1(master_mode_flag, 1'b1);
    fire(9'h008);
    chk1(start_req, 1'b0);
    rchk(S1, 8'h83);
    wr(DT, 8'($urandom));
    rchk(S1, 8'h02);
    fire(9'h010);
    rchk(S1, 8'hc2);
    wr(DT, 8'($urandom));
    rchk(S1, 8'h02);
    fire(9'h020);
    chk1(scl_oe_n, 1'b0);
    rchk(S1, 8'h82);
    wr(CT, 8'h35);
    rchk(S1, 8'h02);
    wr(CT, 8'h37);
    chk1(stop_req, 1'b1);
    fire(9'h040);
    rchk(CT, 8'h35);
    wr(CT, 8'h00);
    rchk(S1, 8'h00);
    $display("test master done");
    // light sleep wakes, deep stop freezes and refuses
    wr(CT, 8'h20);
    wr(CT, 8'h35);
    wait_mode <= 1'b1;
    eng_tx <= 1'b0;
    rx <= 8'($urandom);
    fire(9'h002);
    chk1(wake_req, 1'b1);
    halt_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk1(wake_req, 1'b0);
    chk1(ack_enable, 1'b0);
    rchk(S1, 8'h00);
    fire(9'h001);
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    rchk(S1, sr1_of(1'b0, 1'b0, 1'b1, 1'b0));
    rchk(DT, rx);
    rchk(S1, 8'h00);
    $display("test power done");
    final_report();
  end
endmodule // test_i2c_event_control
